// file: core/brownout_and_startup_timers.v
`timescale 1ns/1ps
`include "brownout_seq_regs.vh"
module brownout_and_startup_timers
#(
  parameter POWERUP_TIMER_PERIODS = `POWERUP_TIMER_PERIODS,
  parameter OST_CYCLES   = `OST_CYCLES,
  parameter PLL_CYCLES   = `PLL_LOCK_US * `REF_CLK_MHZ
)
(
  input  wire       ref_clk,
  input  wire       arst_n,
  input  wire [1:0] brownout_enable_config,
  input  wire [1:0] brownout_level_select,
  input  wire       powerup_timer_disable_n,
  input  wire [2:0] oscMode,
  input  wire       supplyBelow,
  input  wire       reference_stable_flag,
  input  wire       porPulse,
  input  wire       external_reset_n,
  input  wire       sleepMode,
  input  wire       oscStoppedWake,
  input  wire       low_freq_internal_osc,
  input  wire       osc_input_pin,
  input  wire       sbSetReq,
  input  wire       sbClrReq,
  input  wire       flagSetReq,
  output reg        sysReset,
  output reg        software_brownout_enable,
  output reg        brownout_flag,
  output reg        referenceRequest,
  output reg  [1:0] thresholdSelect,
  output reg        brownoutActive
);
  localparam FILT_CYC = (`FILTER_NS + `REF_CLK_NS - 1) / `REF_CLK_NS;
  localparam [7:0] FILT_TGT = FILT_CYC;
  localparam [11:0] POWERUP_TIMER_TGT = POWERUP_TIMER_PERIODS;
  localparam [11:0] OST_TGT  = OST_CYCLES;
  localparam [16:0] PLL_TGT  = PLL_CYCLES;

  // One-hot sequencer states
  localparam [5:0] S_POR  = 6'h01;
  localparam [5:0] S_BOR  = 6'h02;
  localparam [5:0] S_POWERUP_TIMER = 6'h04;
  localparam [5:0] S_OST  = 6'h08;
  localparam [5:0] S_PLL  = 6'h10;
  localparam [5:0] S_RUN  = 6'h20;

  // Crystal or resonator mode decode, used twice
  function isCrystal;
    input [2:0] m;
    begin
      isCrystal = (m == `OSC_LP) || (m == `OSC_XT) || (m == `OSC_HS) || (m == `OSC_HIGH_SPEED_CRYSTAL_PLL_MODE);
    end
  endfunction

  reg  [5:0] state_r;
  reg  [5:0] state_nxt;
  reg  [7:0] filt_r;
  reg        borTrip_r;
  reg        porSeen_r;
  reg        sbBit_r;
  wire       lfTick;
  wire       oscTick;
  wire       pwrtDone;
  wire       ostDone;
  wire       pllDone;
  wire       detectEn;
  wire       sensing;
  wire       useOst;

  // Slow and oscillator clocks brought in as tick pulses
  edge_pulse_sync u_lfSync
  (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .sigIn     (low_freq_internal_osc),
    .risePulse (lfTick)
  );

  edge_pulse_sync u_oscSync
  (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .sigIn     (osc_input_pin),
    .risePulse (oscTick)
  );

  // Detection enable by configuration
  assign detectEn = (brownout_enable_config == `BOR_CFG_ON) ||
                    (brownout_enable_config == `BOR_CFG_SW && sbBit_r) ||
                    (brownout_enable_config == `BOR_CFG_NOSLEEP && !sleepMode);
  assign sensing  = detectEn && reference_stable_flag;
  assign useOst   = isCrystal(oscMode) && (porSeen_r || oscStoppedWake);

  // Brownout filter: trip only after the dip outlasts the filter time
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      filt_r    <= 8'h00;
      borTrip_r <= 1'b0;
    end
    else if (!sensing || !supplyBelow)
    begin
      filt_r    <= 8'h00;
      borTrip_r <= 1'b0;
    end
    else if (filt_r != FILT_TGT)
      filt_r <= filt_r + 8'h01;
    else
      borTrip_r <= 1'b1;
  end

  // Power-up timer: 2048 slow-clock periods
  tick_counter #(.WIDTH(12)) u_powerup_timer
  (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clear   (state_r != S_POWERUP_TIMER),
    .run     (state_r == S_POWERUP_TIMER),
    .tick    (lfTick),
    .target  (POWERUP_TIMER_TGT),
    .done    (pwrtDone)
  );

  // Start-up timer: 1024 oscillator cycles
  tick_counter #(.WIDTH(12)) u_ost
  (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clear   (state_r != S_OST),
    .run     (state_r == S_OST),
    .tick    (oscTick),
    .target  (OST_TGT),
    .done    (ostDone)
  );

  // PLL lock wait counted on the reference clock
  tick_counter #(.WIDTH(17)) u_pll
  (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clear   (state_r != S_PLL),
    .run     (state_r == S_PLL),
    .tick    (1'b1),
    .target  (PLL_TGT),
    .done    (pllDone)
  );

  // Sequencer next state
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      S_POR:
        if (!porPulse)
        begin
          if (!powerup_timer_disable_n)
            state_nxt = S_POWERUP_TIMER;
          else if (useOst)
            state_nxt = S_OST;
          else
            state_nxt = S_RUN;
        end
      S_BOR:
        if (!borTrip_r)
          state_nxt = !powerup_timer_disable_n ? S_POWERUP_TIMER : S_RUN;
      S_POWERUP_TIMER:
        if (pwrtDone)
          state_nxt = useOst ? S_OST : S_RUN;
      S_OST:
        if (ostDone)
          state_nxt = (oscMode == `OSC_HIGH_SPEED_CRYSTAL_PLL_MODE) ? S_PLL : S_RUN;
      S_PLL:
        if (pllDone)
          state_nxt = S_RUN;
      S_RUN:
        if (oscStoppedWake && isCrystal(oscMode))
          state_nxt = S_OST;
      default:
        state_nxt = S_POR;
    endcase
    if (porPulse)
      state_nxt = S_POR;
    else if (borTrip_r)
      state_nxt = S_BOR;
  end

  // State, flags and outputs
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r                  <= S_POR;
      porSeen_r                <= 1'b1;
      sbBit_r                  <= 1'b0;
      sysReset                 <= 1'b1;
      software_brownout_enable <= 1'b0;
      brownout_flag            <= 1'b0;
      referenceRequest         <= 1'b0;
      thresholdSelect          <= 2'b00;
      brownoutActive           <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == S_POR)
        porSeen_r <= 1'b1;
      else if (state_r == S_RUN)
        porSeen_r <= 1'b0;
      // Software bit: reset value by configuration, writable only in 01
      if (state_r == S_POR || state_r == S_BOR)
        sbBit_r <= (brownout_enable_config == `BOR_CFG_SW);
      else if (brownout_enable_config != `BOR_CFG_SW)
        sbBit_r <= 1'b0;
      else if (sbSetReq)
        sbBit_r <= 1'b1;
      else if (sbClrReq)
        sbBit_r <= 1'b0;
      software_brownout_enable <= (brownout_enable_config == `BOR_CFG_SW) && sbBit_r;
      // Clear on event, in all configs but 00, wins over firmware set
      if ((porPulse || borTrip_r) && brownout_enable_config != `BOR_CFG_OFF)
        brownout_flag <= 1'b0;
      else if (flagSetReq)
        brownout_flag <= 1'b1;
      referenceRequest <= detectEn;
      thresholdSelect  <= brownout_level_select;
      brownoutActive   <= sensing;
      // Timer chain ignores the pin; pin only gates final release
      sysReset <= (state_nxt != S_RUN) || !external_reset_n;
    end
  end
endmodule // brownout_and_startup_timers

// file: core/brownout_seq_regs.vh
`ifndef BROWNOUT_SEQ_REGS_VH
`define BROWNOUT_SEQ_REGS_VH
// Brown-out enable configurations
`define BOR_CFG_OFF      2'b00
`define BOR_CFG_SW       2'b01
`define BOR_CFG_NOSLEEP  2'b10
`define BOR_CFG_ON       2'b11
// Oscillator mode encodings
`define OSC_LP           3'h0
`define OSC_XT           3'h1
`define OSC_HS           3'h2
`define OSC_HIGH_SPEED_CRYSTAL_PLL_MODE        3'h3
`define OSC_EC           3'h4
`define OSC_RC           3'h5
`define OSC_INT          3'h6
// Timer lengths
`define POWERUP_TIMER_PERIODS     2048
`define OST_CYCLES       1024
`define PLL_LOCK_US      2000
`define REF_CLK_MHZ      25
`define FILTER_NS        200
`define REF_CLK_NS       40
`endif

// file: core/edge_pulse_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser of a slow clock with rising-edge pulse out
module edge_pulse_sync
(
  input  wire ref_clk,
  input  wire arst_n,
  input  wire sigIn,
  output reg  risePulse
);
  reg meta_r;
  reg sync_r;
  reg last_r;

  // Sync chain and edge detect on second stage only
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r    <= 1'b0;
      sync_r    <= 1'b0;
      last_r    <= 1'b0;
      risePulse <= 1'b0;
    end
    else
    begin
      meta_r    <= sigIn;
      sync_r    <= meta_r;
      last_r    <= sync_r;
      risePulse <= sync_r & ~last_r;
    end
  end
endmodule // edge_pulse_sync

// file: core/tick_counter.v
`timescale 1ns/1ps
// Counts ticks while running; done stays high while running once the count is reached
module tick_counter
#(
  parameter WIDTH = 12
)
(
  input  wire             ref_clk,
  input  wire             arst_n,
  input  wire             clear,
  input  wire             run,
  input  wire             tick,
  input  wire [WIDTH-1:0] target,
  output wire             done
);
  reg [WIDTH-1:0] count_r;

  // Clear wins; count ticks while running
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      count_r <= {WIDTH{1'b0}};
    else if (clear)
      count_r <= {WIDTH{1'b0}};
    else if (run && tick && count_r != target)
      count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  assign done = run && (count_r == target);
endmodule // tick_counter

// file: tb/brownout_and_startup_timers_bench.sv
`timescale 1ns/1ps
module brownout_and_startup_timers_bench;
  logic       ref_clk, arst_n, powerup_timer_disable_n, supplyBelow, reference_stable_flag, porPulse;
  logic       external_reset_n, sleepMode, oscStoppedWake, low_freq_internal_osc, osc_input_pin;
  logic       sbSetReq, sbClrReq, flagSetReq, sysReset, software_brownout_enable, brownout_flag;
  logic       referenceRequest, brownoutActive, r;
  logic [1:0] brownout_enable_config, brownout_level_select, thresholdSelect;
  logic [2:0] oscMode;
  int         num_errors, checks_done, n, ph;
  brownout_and_startup_timers #(.POWERUP_TIMER_PERIODS(8), .OST_CYCLES(4), .PLL_CYCLES(10)) brownout_and_startup_timers_i (.*);
  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Slow oscillator and crystal stimulus
  always @(posedge ref_clk)
  begin
    ph <= ph + 1;
    if (ph % 4 == 0) low_freq_internal_osc <= ~low_freq_internal_osc;
    if (ph % 3 == 0) osc_input_pin <= ~osc_input_pin;
  end
  task chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Reset, configure, then end the power-on pulse
  task boot(input logic [1:0] c, input logic pd, input logic [2:0] o);
    @(posedge ref_clk);
    brownout_enable_config <= c;
    powerup_timer_disable_n <= pd;
    oscMode <= o;
    arst_n <= 1'b0;
    porPulse <= 1'b1;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    porPulse <= 1'b0;
  endtask
  // Cycles until reset drops, within a window
  task rel(input int lo, input int hi, input string m);
    n = 0;
    while (sysReset !== 1'b0 && n < 400)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(n >= lo && n <= hi, m);
  endtask
  task dip(input int k, output logic rr);
    supplyBelow <= 1'b1;
    repeat (k) @(posedge ref_clk);
    rr = sysReset;
    supplyBelow <= 1'b0;
  endtask
  task t_start;
    boot(2'b00, 1'b1, 3'h5);
    rel(1, 4, "plain mode delay");
    boot(2'b00, 1'b1, 3'h4);
    rel(1, 4, "external clock delay");
    boot(2'b00, 1'b0, 3'h5);
    rel(50, 82, "power-up delay");
    chk(thresholdSelect === 2'b10, "threshold");
  endtask
  task t_crystal;
    boot(2'b00, 1'b1, 3'h2);
    rel(16, 34, "start-up delay");
    boot(2'b00, 1'b1, 3'h3);
    rel(26, 46, "lock delay");
    boot(2'b00, 1'b0, 3'h1);
    rel(66, 118, "chained delay");
  endtask
  task t_pin;
    external_reset_n <= 1'b0;
    boot(2'b00, 1'b0, 3'h2);
    repeat (150) @(posedge ref_clk);
    chk(sysReset === 1'b1, "pin low held");
    external_reset_n <= 1'b1;
    rel(1, 4, "pin release");
  endtask
  task t_bor;
    boot(2'b11, 1'b0, 3'h5);
    rel(50, 82, "boot");
    chk(brownout_flag === 1'b0 && referenceRequest === 1'b1, "flag or ref");
    flagSetReq <= 1'b1;
    @(posedge ref_clk);
    flagSetReq <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(brownout_flag === 1'b1, "flag set");
    dip(20, r);
    chk(r === 1'b1, "no brownout reset");
    repeat (30) @(posedge ref_clk);
    dip(20, r);
    rel(50, 82, "timer restart");
    chk(brownout_flag === 1'b0, "flag cleared");
    boot(2'b11, 1'b1, 3'h5);
    rel(1, 4, "boot");
    dip(20, r);
    rel(1, 5, "no timer after brownout");
  endtask
  task t_sw;
    boot(2'b01, 1'b1, 3'h5);
    rel(1, 4, "boot");
    chk(software_brownout_enable === 1'b1, "sw reset value");
    dip(20, r);
    chk(r === 1'b1, "sw on no reset");
    rel(1, 5, "recover");
    sbClrReq <= 1'b1;
    @(posedge ref_clk);
    sbClrReq <= 1'b0;
    repeat (3) @(posedge ref_clk);
    dip(20, r);
    chk(r === 1'b0 && software_brownout_enable === 1'b0, "sw off");
  endtask
  task t_gate;
    boot(2'b00, 1'b1, 3'h5);
    rel(1, 4, "boot");
    sbSetReq <= 1'b1;
    @(posedge ref_clk);
    sbSetReq <= 1'b0;
    dip(20, r);
    chk(r === 1'b0 && software_brownout_enable === 1'b0, "off config");
    boot(2'b10, 1'b1, 3'h5);
    rel(1, 4, "boot");
    sleepMode <= 1'b1;
    repeat (3) @(posedge ref_clk);
    dip(20, r);
    chk(r === 1'b0, "sleep reset");
    @(posedge ref_clk);
    sleepMode <= 1'b0;
    repeat (3) @(posedge ref_clk);
    dip(20, r);
    chk(r === 1'b1, "wake no reset");
    boot(2'b11, 1'b1, 3'h5);
    rel(1, 4, "boot");
    reference_stable_flag <= 1'b0;
    repeat (2) @(posedge ref_clk);
    dip(20, r);
    chk(r === 1'b0, "unsettled reset");
  endtask
  task results;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {arst_n, supplyBelow, sleepMode, oscStoppedWake, low_freq_internal_osc, osc_input_pin} = '0;
    {sbSetReq, sbClrReq, flagSetReq, brownout_enable_config, oscMode} = '0;
    {porPulse, reference_stable_flag, external_reset_n, powerup_timer_disable_n} = 4'hf;
    brownout_level_select = 2'b10;
    t_start;
    t_crystal;
    t_pin;
    t_bor;
    t_sw;
    t_gate;
    results;
  end
  // Watchdog
  initial
  begin
    #300us;
    num_errors++;
    results;
  end
endmodule // brownout_and_startup_timers_bench

// file: tb/brownout_timers_properties.sv
`timescale 1ns/1ps
module brownout_timers_properties
#(
  parameter POWERUP_TIMER_PERIODS = 8,
  parameter OST_CYCLES   = 4,
  parameter PLL_CYCLES   = 10
)
(
  input wire       ref_clk,
  input wire       arst_n,
  input wire [1:0] brownout_enable_config,
  input wire [1:0] brownout_level_select,
  input wire       powerup_timer_disable_n,
  input wire [2:0] oscMode,
  input wire       supplyBelow,
  input wire       reference_stable_flag,
  input wire       porPulse,
  input wire       external_reset_n,
  input wire       sleepMode,
  input wire       oscStoppedWake,
  input wire       low_freq_internal_osc,
  input wire       osc_input_pin,
  input wire       sbSetReq,
  input wire       sbClrReq,
  input wire       flagSetReq,
  input wire       sysReset,
  input wire       software_brownout_enable,
  input wire       brownout_flag,
  input wire       referenceRequest,
  input wire [1:0] thresholdSelect,
  input wire       brownoutActive
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Supply low while sensing, longer than the filter
  sequence sDip;
    (brownoutActive && supplyBelow) [*8];
  endsequence
  // Dip continuing after the trip
  sequence sLongDip;
    sDip ##1 supplyBelow [*4];
  endsequence
  AST_BOR_TRIP: assert property (sDip |-> ##[0:2] sysReset)
    else $error("long dip gave no reset");
  AST_BOR_HOLD: assert property (sLongDip |-> sysReset)
    else $error("reset dropped while supply low");
  AST_POR_HOLD: assert property (porPulse |=> sysReset)
    else $error("no reset after power-on pulse");
  AST_PIN_HOLD: assert property (!external_reset_n |=> sysReset)
    else $error("no reset while pin low");
  AST_RC_FAST: assert property ($fell(porPulse) && oscMode == 3'h5 && powerup_timer_disable_n
    && external_reset_n && !supplyBelow |-> ##[1:3] !sysReset)
    else $error("slow release in plain mode");
  AST_SWB_OFF: assert property (brownout_enable_config != 2'b01
    && $past(brownout_enable_config) != 2'b01 |-> !software_brownout_enable)
    else $error("software bit reads 1");
  AST_CFG_OFF: assert property (brownout_enable_config == 2'b00
    && $past(brownout_enable_config) == 2'b00 |-> !brownoutActive)
    else $error("detection on in off config");
  AST_SLEEP_OFF: assert property (brownout_enable_config == 2'b10 && sleepMode
    && $past(brownout_enable_config) == 2'b10 && $past(sleepMode) |-> !brownoutActive)
    else $error("detection on in sleep");
  AST_NO_REF: assert property (!reference_stable_flag && !$past(reference_stable_flag)
    |-> !brownoutActive)
    else $error("detection before reference stable");
  AST_THRESH: assert property ($past(arst_n) && $stable(brownout_level_select)
    |-> thresholdSelect == brownout_level_select)
    else $error("threshold not from config");
  AST_REF_REQ: assert property ($past(arst_n) && brownout_enable_config == 2'b11
    && $past(brownout_enable_config) == 2'b11 |-> referenceRequest)
    else $error("reference not requested");
endmodule // brownout_timers_properties
bind brownout_and_startup_timers brownout_timers_properties
  #(.POWERUP_TIMER_PERIODS(POWERUP_TIMER_PERIODS), .OST_CYCLES(OST_CYCLES), .PLL_CYCLES(PLL_CYCLES)) props_i (.*);
